// >>> ass_pkg.sv
// Package for the automatic speed stage sequencer
package ass_pkg;
   localparam int STAGES = 16;
   localparam int IDX_W = 4;
   localparam int FREQ_W = 16;
   localparam int TIME_W = 16;
   localparam int DIR_W = 2;
   localparam int MODE_W = 3;
   // Register indices on the plain register port
   localparam logic [7:0] OFF_MODE = 8'h00;
   localparam logic [7:0] OFF_FREQ0 = 8'h01;
   localparam logic [7:0] OFF_STATUS = 8'h02;
   localparam logic [7:0] OFF_FREQ_BASE = 8'h10;
   localparam logic [7:0] OFF_TIME_BASE = 8'h20;
   localparam logic [7:0] OFF_DIR_BASE = 8'h30;
   localparam logic [MODE_W-1:0] MODE_RESET = 3'h0;
   localparam logic [FREQ_W-1:0] FREQ_RESET = 16'h0000;
   // Durations are in units of 0.1 s
   localparam int TICK_NS = 100_000_000;
   localparam int CLK_NS = 100;
   localparam int TICK_CYCLES = TICK_NS / CLK_NS;
   localparam logic [1:0] DIR_STOP = 2'h0;
   localparam logic [1:0] DIR_FWD = 2'h1;
   localparam logic [1:0] DIR_REV = 2'h2;
   typedef enum logic [1:0] {DRV_STOP, DRV_FWD, DRV_REV} ass_dir_t;
   typedef struct packed {
      logic [FREQ_W-1:0] freq;
      logic [1:0] dir;
      logic run;
   } ass_cmd_t;
endpackage

// >>> ass_stage_mem.sv
// Per-stage frequency memory, registered read
`timescale 1ns/10ps
`default_nettype none
module ass_stage_mem (
   input wire logic sys_clk,
   input wire logic we,
   input wire logic [ass_pkg::IDX_W-1:0] waddr,
   input wire logic [ass_pkg::FREQ_W-1:0] wdata,
   input wire logic [ass_pkg::IDX_W-1:0] raddr,
   output logic [ass_pkg::FREQ_W-1:0] rdata
);
   logic [ass_pkg::FREQ_W-1:0] mem [ass_pkg::STAGES];
   always_ff @(posedge sys_clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule
`default_nettype wire

// >>> ass_sequencer.sv
// Automatic speed stage sequencer top
//
// Functional notes
// - Mode 0 disables sequencing; the normal frequency reference drives.
// - Modes 1 and 4 run the stage list once, then stop.
// - Modes 2 and 5 repeat the stage list while run stays on.
// - Modes 3 and 6 do one pass then hold last stage frequency.
// - Modes 1 to 3 resume the unfinished stage after a stop.
// - Modes 4 to 6 restart from stage zero after a stop.
// - Stage zero uses multi-speed zero frequency; each stage has time, direction.
// - Direction code 0 stop, 1 forward, 2 reverse.
// - Wobble or PID active inhibits sequencing.
// - While sequencing, external multi-step speed selects are ignored.
// - Zero duration stage is skipped; all zero means no sequencing.
// - Ramps between stages use primary accel and decel settings.
`timescale 1ns/10ps
`default_nettype none
module ass_sequencer (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [15:0] reg_rdata,
   input wire logic run_cmd,
   input wire logic wobble_active,
   input wire logic pid_active,
   input wire logic [15:0] normal_freq,
   input wire logic [1:0] normal_dir,
   input wire logic [3:0] step_sel_in,
   output logic [3:0] step_sel_out,
   output logic [15:0] out_freq,
   output logic [1:0] out_dir,
   output logic out_run,
   output logic use_main_ramp,
   output logic seq_active,
   output logic [3:0] stage_out
);
   // ************************************************************
   // Register storage
   // ************************************************************
   typedef enum logic [1:0] {S_IDLE, S_LOAD, S_RUN, S_DONE} ass_state_t;
   logic [2:0] mode_reg;
   logic [15:0] freq0_reg;
   logic [15:0] time_reg [ass_pkg::STAGES];
   logic [1:0] dir_reg [ass_pkg::STAGES];
   logic [15:0] freq_rd;
   logic [15:0] rdata_next;
   logic [15:0] reg_rdata_reg;
   // Pin inputs pass three flops; run counts once stages two and three agree
   logic [2:0] run_sync_reg;
   logic [2:0] wob_sync_reg;
   logic [2:0] pid_sync_reg;
   logic run_reg;
   logic wob_reg;
   logic pid_reg;
   ass_state_t state_reg;
   logic [3:0] idx_reg;
   logic [15:0] tleft_reg;
   logic [23:0] tick_cnt_reg;
   logic tick;
   logic [15:0] out_freq_reg;
   logic [1:0] out_dir_reg;
   logic out_run_reg;
   logic seq_active_reg;
   logic [3:0] step_sel_reg;
   wire sel_mode = (reg_addr == ass_pkg::OFF_MODE);
   wire sel_f0 = (reg_addr == ass_pkg::OFF_FREQ0);
   wire sel_stat = (reg_addr == ass_pkg::OFF_STATUS);
   wire sel_freq = (reg_addr[7:4] == ass_pkg::OFF_FREQ_BASE[7:4]);
   wire sel_time = (reg_addr[7:4] == ass_pkg::OFF_TIME_BASE[7:4]);
   wire sel_dir = (reg_addr[7:4] == ass_pkg::OFF_DIR_BASE[7:4]);
   logic [3:0] next_idx;
   logic [3:0] mem_raddr;
   wire [3:0] ra = reg_addr[3:0];
   wire mem_we = reg_write && sel_freq && (ra != 4'h0);
   // Stage zero frequency lives outside the memory
   ass_stage_mem u_mem (
      .sys_clk(sys_clk),
      .we(mem_we),
      .waddr(ra),
      .wdata(reg_wdata),
      .raddr(mem_raddr),
      .rdata(freq_rd)
   );
   // ************************************************************
   // Sequencing conditions
   // ************************************************************
   logic any_time;
   always_comb begin
      any_time = 1'b0;
      for (int i = 0; i < ass_pkg::STAGES; i++) begin
         any_time = any_time | (time_reg[i] != 16'h0000);
      end
   end
   wire mode_on = (mode_reg >= 3'h1) && (mode_reg <= 3'h6);
   wire enabled = mode_on && !wob_reg && !pid_reg && any_time;
   wire single = (mode_reg == 3'h1) || (mode_reg == 3'h4);
   wire loop = (mode_reg == 3'h2) || (mode_reg == 3'h5);
   wire restart0 = (mode_reg >= 3'h4);
   // First active stage at or after a start point, ascending
   logic [3:0] scan_idx;
   logic scan_found;
   logic scan_wrap;
   // One bit wider, so leaving stage fifteen still counts as the end of the list
   logic [4:0] scan_from;
   assign scan_from = (state_reg == S_RUN) ? {1'b0, idx_reg} + 5'h01 : {1'b0, idx_reg};
   always_comb begin
      scan_idx = scan_from[3:0];
      scan_found = 1'b0;
      scan_wrap = 1'b0;
      for (int k = 0; k < 2 * ass_pkg::STAGES; k++) begin
         if (!scan_found) begin
            if (k >= ass_pkg::STAGES - int'(scan_from) && (state_reg == S_RUN)) begin
               scan_wrap = 1'b1;
            end
            if (time_reg[4'(int'(scan_from) + k)] != 16'h0000) begin
               scan_found = 1'b1;
               scan_idx = 4'(int'(scan_from) + k);
            end
         end
      end
   end
   // Reaching the end of the list only counts when leaving the current stage
   wire pass_end = scan_wrap;
   assign next_idx = scan_idx;
   // Memory reads the index held next cycle, so its registered output lines up
   wire load_new = (state_reg == S_LOAD) && (tleft_reg == 16'h0000);
   wire step_new = (state_reg == S_RUN) && run_reg && enabled && tick &&
                   (tleft_reg <= 16'h0001) && !(pass_end && !loop);
   assign mem_raddr = (reg_read && sel_freq) ? ra : ((load_new || step_new) ? next_idx : idx_reg);
   // A register read borrows the memory port; the drive keeps the last value
   logic mem_lent_reg;
   logic [15:0] stage_freq_reg;
   wire [15:0] cur_freq = (idx_reg == 4'h0) ? freq0_reg :
                          (mem_lent_reg ? stage_freq_reg : freq_rd);
   // ************************************************************
   // Timebase and registers
   // ************************************************************
   assign tick = (tick_cnt_reg == 24'(ass_pkg::TICK_CYCLES - 1));
   always_comb begin
      rdata_next = 16'h0000;
      if (sel_mode) begin
         rdata_next = {13'h0000, mode_reg};
      end else if (sel_f0) begin
         rdata_next = freq0_reg;
      end else if (sel_stat) begin
         rdata_next = {8'h00, seq_active_reg, 1'b0, state_reg, idx_reg};
      end else if (sel_time) begin
         rdata_next = time_reg[ra];
      end else if (sel_dir) begin
         rdata_next = {14'h0000, dir_reg[ra]};
      end
   end
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         mode_reg <= ass_pkg::MODE_RESET;
         freq0_reg <= ass_pkg::FREQ_RESET;
         for (int i = 0; i < ass_pkg::STAGES; i++) begin
            time_reg[i] <= 16'h0000;
            dir_reg[i] <= ass_pkg::DIR_STOP;
         end
         reg_rdata_reg <= 16'h0000;
      end else begin
         if (reg_write && sel_mode) begin
            mode_reg <= reg_wdata[2:0];
         end
         if (reg_write && sel_f0) begin
            freq0_reg <= reg_wdata;
         end
         if (reg_write && sel_time) begin
            time_reg[ra] <= reg_wdata;
         end
         if (reg_write && sel_dir) begin
            dir_reg[ra] <= reg_wdata[1:0];
         end
         reg_rdata_reg <= reg_read ? rdata_next : 16'h0000;
      end
   end
   // Frequency read overrides when addressing the stage memory
   logic rd_freq_reg;
   logic rd_f0_reg;
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         rd_freq_reg <= 1'b0;
         rd_f0_reg <= 1'b0;
         mem_lent_reg <= 1'b0;
         stage_freq_reg <= ass_pkg::FREQ_RESET;
      end else begin
         rd_freq_reg <= reg_read && sel_freq && (ra != 4'h0);
         rd_f0_reg <= reg_read && sel_freq && (ra == 4'h0);
         mem_lent_reg <= reg_read && sel_freq;
         if (!mem_lent_reg) begin
            stage_freq_reg <= freq_rd;
         end
      end
   end
   assign reg_rdata = rd_freq_reg ? freq_rd : (rd_f0_reg ? freq0_reg : reg_rdata_reg);
   // ************************************************************
   // Sequencer
   // ************************************************************
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         run_sync_reg <= 3'h0;
         wob_sync_reg <= 3'h0;
         pid_sync_reg <= 3'h0;
         run_reg <= 1'b0;
         wob_reg <= 1'b0;
         pid_reg <= 1'b0;
         tick_cnt_reg <= 24'h000000;
         state_reg <= S_IDLE;
         idx_reg <= 4'h0;
         tleft_reg <= 16'h0000;
      end else begin
         run_sync_reg <= {run_sync_reg[1:0], run_cmd};
         wob_sync_reg <= {wob_sync_reg[1:0], wobble_active};
         pid_sync_reg <= {pid_sync_reg[1:0], pid_active};
         if (run_sync_reg[2] == run_sync_reg[1]) run_reg <= run_sync_reg[2];
         if (wob_sync_reg[2] == wob_sync_reg[1]) wob_reg <= wob_sync_reg[2];
         if (pid_sync_reg[2] == pid_sync_reg[1]) pid_reg <= pid_sync_reg[2];
         tick_cnt_reg <= tick ? 24'h000000 : tick_cnt_reg + 24'h000001;
         case (state_reg)
            S_IDLE: begin
               if (run_reg && enabled) begin
                  if (restart0) begin
                     idx_reg <= 4'h0;
                     tleft_reg <= 16'h0000;
                  end
                  state_reg <= S_LOAD;
               end
            end
            S_LOAD: begin
               // Resume keeps remaining time; fresh stage loads full time
               if (tleft_reg == 16'h0000) begin
                  idx_reg <= next_idx;
                  tleft_reg <= time_reg[next_idx];
               end
               state_reg <= S_RUN;
            end
            S_RUN: begin
               if (!run_reg || !enabled) begin
                  state_reg <= S_IDLE;
                  if (restart0) begin
                     idx_reg <= 4'h0;
                     tleft_reg <= 16'h0000;
                  end
               end else if (tick) begin
                  if (tleft_reg > 16'h0001) begin
                     tleft_reg <= tleft_reg - 16'h0001;
                  end else if (pass_end && !loop) begin
                     tleft_reg <= 16'h0000;
                     state_reg <= S_DONE;
                  end else begin
                     idx_reg <= next_idx;
                     tleft_reg <= time_reg[next_idx];
                  end
               end
            end
            S_DONE: begin
               if (!run_reg || !enabled) begin
                  state_reg <= S_IDLE;
                  idx_reg <= 4'h0;
                  tleft_reg <= 16'h0000;
               end
            end
            default: state_reg <= S_IDLE;
         endcase
      end
   end
   // ************************************************************
   // Outputs to the drive
   // ************************************************************
   wire running = (state_reg == S_RUN) || (state_reg == S_DONE && !single);
   wire seq_now = enabled && (state_reg != S_IDLE);
   ass_pkg::ass_cmd_t cmd_next;
   always_comb begin
      cmd_next.freq = normal_freq;
      cmd_next.dir = normal_dir;
      cmd_next.run = run_reg;
      if (seq_now) begin
         cmd_next.freq = cur_freq;
         cmd_next.dir = (dir_reg[idx_reg] == ass_pkg::DIR_REV) ? ass_pkg::DIR_REV :
                        (dir_reg[idx_reg] == ass_pkg::DIR_FWD) ? ass_pkg::DIR_FWD :
                        ass_pkg::DIR_STOP;
         cmd_next.run = running && (cmd_next.dir != ass_pkg::DIR_STOP);
      end
   end
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         out_freq_reg <= 16'h0000;
         out_dir_reg <= ass_pkg::DIR_STOP;
         out_run_reg <= 1'b0;
         seq_active_reg <= 1'b0;
         step_sel_reg <= 4'h0;
      end else begin
         out_freq_reg <= cmd_next.freq;
         out_dir_reg <= cmd_next.dir;
         out_run_reg <= cmd_next.run;
         seq_active_reg <= seq_now;
         step_sel_reg <= seq_now ? 4'h0 : step_sel_in;
      end
   end
   assign out_freq = out_freq_reg;
   assign out_dir = out_dir_reg;
   assign out_run = out_run_reg;
   assign seq_active = seq_active_reg;
   assign use_main_ramp = seq_active_reg;
   assign step_sel_out = step_sel_reg;
   assign stage_out = idx_reg;
endmodule
`default_nettype wire

// >>> ass_drive_model.sv
// Model of the drive output stage and run command source
`timescale 1ns/10ps
`default_nettype none
module ass_drive_model (
   input wire logic sys_clk,
   input wire logic run_req,
   input wire ass_pkg::ass_cmd_t cmd,
   output logic run_cmd,
   output var ass_pkg::ass_cmd_t applied
);
   // ************************************************
   // Operator run lever and drive power stage
   // ************************************************
   assign run_cmd = run_req;
   // A stopped drive shows zero speed, not the last command
   always_ff @(posedge sys_clk) begin
      applied <= cmd.run ? cmd : '0;
   end
endmodule
`default_nettype wire

// >>> ass_sequencer_sva.sv
// Port checker for the stage sequencer
`timescale 1ns/10ps
`default_nettype none
module ass_sequencer_chk (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic run_cmd,
   input wire logic wobble_active,
   input wire logic pid_active,
   input wire logic [15:0] normal_freq,
   input wire logic [3:0] step_sel_out,
   input wire logic [15:0] out_freq,
   input wire logic [1:0] out_dir,
   input wire logic out_run,
   input wire logic use_main_ramp,
   input wire logic seq_active,
   input wire logic [3:0] stage_out
);
   // ************************************************
   // Properties
   // ************************************************
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   step_mask_a: assert property (seq_active && $past(seq_active) |-> step_sel_out == 4'h0)
      else $error("step select leaks while sequencing");
   ramp_sel_a: assert property ($rose(seq_active) |-> ##[0:1] use_main_ramp)
      else $error("primary ramp not selected");
   seq_inhibit_a: assert property ((wobble_active || pid_active) [*8] |-> !seq_active)
      else $error("sequencing while wobble or pid");
   dir_legal_a: assert property (out_run |-> out_dir != 2'h3)
      else $error("illegal direction while running");
   stop_dir_a: assert property (seq_active && out_dir == 2'h0 |-> !out_run)
      else $error("stop stage still runs");
   stage_order_a: assert property (seq_active && $past(seq_active) && $changed(stage_out)
      |-> stage_out > $past(stage_out) || stage_out == 4'h0) else $error("stage went backwards");
   normal_ref_a: assert property ((!seq_active && $stable(normal_freq)) [*4]
      |-> out_freq == normal_freq) else $error("idle output not normal reference");
   run_gone_a: assert property (!run_cmd [*8] |-> !seq_active)
      else $error("sequencing without run command");
   cover property (seq_active && out_run && out_dir == 2'h2);
   cover property ($fell(seq_active) && run_cmd);
   cover property (seq_active && !out_run);
endmodule
bind ass_sequencer ass_sequencer_chk i_ass_sequencer_chk (.sys_clk, .reset_n, .run_cmd,
   .wobble_active, .pid_active, .normal_freq, .step_sel_out, .out_freq, .out_dir, .out_run,
   .use_main_ramp, .seq_active, .stage_out);
`default_nettype wire

// >>> tb_auto_speed_stage_sequencer.sv
// Self-checking testbench for the stage sequencer
`timescale 1ns/10ps
`default_nettype none
module tb_auto_speed_stage_sequencer;
   logic sys_clk, reset_n, reg_write, reg_read, run_req, wobble_active, pid_active, run_cmd;
   logic [7:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata, normal_freq, out_freq;
   logic [3:0] step_sel_in, step_sel_out, stage_out;
   logic [1:0] normal_dir, out_dir;
   logic out_run, use_main_ramp, seq_active;
   ass_pkg::ass_cmd_t applied;
   int error_cnt = 0;
   int cmp_count = 0;
   ass_sequencer i_ass_sequencer (.sys_clk, .reset_n, .reg_addr, .reg_wdata, .reg_write,
      .reg_read, .reg_rdata, .run_cmd, .wobble_active, .pid_active, .normal_freq, .normal_dir,
      .step_sel_in, .step_sel_out, .out_freq, .out_dir, .out_run, .use_main_ramp, .seq_active,
      .stage_out);
   ass_drive_model i_ass_drive_model (.sys_clk, .run_req, .cmd({out_freq, out_dir, out_run}),
      .run_cmd, .applied);
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   // ************************************************
   // Shared tasks
   // ************************************************
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic summarize();
      $display("compares %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge sys_clk);
      reg_write <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string what);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge sys_clk);
      reg_read <= 1'b0;
      #1;
      chk(reg_rdata, exp, what);
   endtask
   // Input filter takes several cycles, so each change settles for twelve
   task automatic run(input logic v);
      @(posedge sys_clk);
      run_req <= v;
      repeat (12) @(negedge sys_clk);
   endtask
   task automatic wait_seq(input logic want);
      int n;
      n = 0;
      while (seq_active !== want && n < 40) begin
         @(negedge sys_clk);
         n++;
      end
      if (seq_active !== want) begin
         error_cnt++;
         summarize();
      end
      repeat (8) @(negedge sys_clk);
   endtask
   // ************************************************
   // Scenarios; a stage tick is a million cycles, so no stage ever expires here
   // ************************************************
   task automatic t_regs();
      rd(8'h00, 16'h0000, "mode reset");
      wr(8'h00, 16'h0006);
      rd(8'h00, 16'h0006, "mode");
      wr(8'h1F, 16'hABCD);
      rd(8'h1F, 16'hABCD, "stage15 freq");
      rd(8'hFF, 16'h0000, "unmapped");
   endtask
   task automatic t_mode_off();
      wr(8'h00, 16'h0000);
      wr(8'h20, 16'h0005);
      wr(8'h30, 16'h0001);
      run(1'b1);
      chk({15'h0, seq_active}, 16'h0000, "mode0 active");
      chk(out_freq, normal_freq, "mode0 freq");
      run(1'b0);
   endtask
   task automatic t_all_zero();
      wr(8'h20, 16'h0000);
      wr(8'h00, 16'h0001);
      run(1'b1);
      chk({15'h0, seq_active}, 16'h0000, "zero times");
      run(1'b0);
   endtask
   task automatic t_stage_dirs();
      logic [1:0] d;
      wr(8'h01, 16'h0F00);
      wr(8'h20, 16'h0005);
      for (int m = 1; m <= 6; m++) begin
         d = 2'(m % 3);
         wr(8'h30, {14'h0, d});
         wr(8'h00, 16'(m));
         step_sel_in <= 4'hA;
         run(1'b1);
         wait_seq(1'b1);
         chk({12'h0, step_sel_out}, 16'h0000, "masked select");
         chk({12'h0, stage_out}, 16'h0000, "first stage");
         chk({14'h0, out_dir}, {14'h0, d}, "stage dir");
         chk({15'h0, out_run}, {15'h0, d != 2'h0}, "stage run");
         chk(applied.freq, (d != 2'h0) ? 16'h0F00 : 16'h0000, "drive freq");
         chk({15'h0, use_main_ramp}, 16'h0001, "main ramp");
         run(1'b0);
         wait_seq(1'b0);
         chk({12'h0, step_sel_out}, 16'h000A, "select passes");
      end
   endtask
   task automatic t_inhibit();
      wr(8'h30, 16'h0002);
      wr(8'h00, 16'h0002);
      run(1'b1);
      wait_seq(1'b1);
      for (int k = 1; k <= 2; k++) begin
         @(posedge sys_clk);
         {pid_active, wobble_active} <= 2'(k);
         wait_seq(1'b0);
         chk(out_freq, normal_freq, "inhibited freq");
         @(posedge sys_clk);
         {pid_active, wobble_active} <= 2'h0;
         wait_seq(1'b1);
         chk({12'h0, stage_out}, 16'h0000, "resumed stage");
      end
      run(1'b0);
   endtask
   task automatic t_skip();
      wr(8'h20, 16'h0000);
      wr(8'h22, 16'h0005);
      wr(8'h24, 16'h0005);
      wr(8'h12, 16'h0456);
      wr(8'h14, 16'h0789);
      wr(8'h32, 16'h0001);
      wr(8'h00, 16'h0005);
      run(1'b1);
      wait_seq(1'b1);
      chk({12'h0, stage_out}, 16'h0002, "skip to stage2");
      chk(out_freq, 16'h0456, "stage2 freq");
      chk({14'h0, out_dir}, 16'h0001, "stage2 dir");
      rd(8'h14, 16'h0789, "stage4 freq");
      repeat (2) @(negedge sys_clk);
      chk(out_freq, 16'h0456, "freq across read");
      run(1'b0);
      wait_seq(1'b0);
      chk({12'h0, stage_out}, 16'h0000, "restart stage");
      wr(8'h00, 16'h0002);
      run(1'b1);
      wait_seq(1'b1);
      run(1'b0);
      wait_seq(1'b0);
      chk({12'h0, stage_out}, 16'h0002, "kept stage");
   endtask
   initial begin
      reset_n = 1'b0;
      {reg_addr, reg_wdata, reg_write, reg_read, run_req} = '0;
      {wobble_active, pid_active, normal_dir, step_sel_in} = '0;
      normal_freq = 16'h0123;
      repeat (20) @(posedge sys_clk);
      reset_n <= 1'b1;
      t_regs();
      t_mode_off();
      t_all_zero();
      t_stage_dirs();
      t_inhibit();
      t_skip();
      summarize();
   end
endmodule
`default_nettype wire
